// file: src/cfg_startup_pkg.sv
package cfg_startup_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int POR_RELEASE_NS = 5000;
  localparam int POR_CYCLES     = POR_RELEASE_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES   = 4;
  localparam int STEP_CYCLES    = 4;
  localparam int CNT_W          = 8;
  // ==========================================================
  // Register map
  localparam int         AW          = 4;
  localparam logic [3:0] OFS_OPTIONS = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_COUNT   = 4'hc;
  localparam logic [6:0] OPTIONS_RST = 7'h00;
  localparam int         CTRL_CLRERR = 0;
  localparam int         STAT_ERR    = 4;
  localparam int         STAT_USER   = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef struct packed {
    logic serialScheme;
    logic compress;
    logic initDoneEn;
    logic chipOe;
    logic chipReset;
    logic clearsFirst;
    logic autoRestart;
  } options_t;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       error;
    logic [7:0] data;
  } frame_t;
  typedef enum logic [2:0] {
    ST_POWERUP  = 3'h0,
    ST_RESET    = 3'h1,
    ST_WAIT     = 3'h2,
    ST_CONFIG   = 3'h3,
    ST_ERRHOLD  = 3'h4,
    ST_ERRPULSE = 3'h5,
    ST_INIT     = 3'h6,
    ST_USER     = 3'h7
  } state_t;
endpackage

// file: src/cfg_decompressor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Zero-run expander: 0x00 then n gives n+1 zero bytes
module cfg_decompressor (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       compress,
  input  wire logic       inValid,
  input  wire logic       inLast,
  input  wire logic [7:0] inData,
  output var  logic       inReady,
  output var  logic       outValid,
  output var  logic       outLast,
  output var  logic [7:0] outData
);
  logic [7:0] runFf;
  logic       expectFf;
  logic       runLastFf;
  logic       take;
  logic [7:0] nxt_run;

  assign take = inValid && inReady;

  always_comb begin
    nxt_run = runFf;
    if (runFf != 8'h00) begin
      nxt_run = runFf - 8'h01;
    end else if (take && compress && expectFf) begin
      nxt_run = inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runFf     <= 8'h00;
      expectFf  <= 1'b0;
      runLastFf <= 1'b0;
      inReady   <= 1'b0;
      outValid  <= 1'b0;
      outLast   <= 1'b0;
      outData   <= 8'h00;
    end else if (!enable) begin
      runFf    <= 8'h00;
      expectFf <= 1'b0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
      outLast  <= 1'b0;
    end else begin
      runFf    <= nxt_run;
      inReady  <= (nxt_run == 8'h00);
      outValid <= 1'b0;
      outLast  <= 1'b0;
      if (runFf != 8'h00) begin
        outValid <= 1'b1;
        outData  <= 8'h00;
        outLast  <= (runFf == 8'h01) && runLastFf;
      end else if (take && compress && expectFf) begin // RULE17
        expectFf  <= 1'b0;
        runLastFf <= inLast;
        outValid  <= 1'b1;
        outData   <= 8'h00;
        outLast   <= inLast && (inData == 8'h00);
      end else if (take && compress && inData == 8'h00) begin
        expectFf <= 1'b1;
      end else if (take) begin // RULE18
        outValid <= 1'b1;
        outData  <= inData;
        outLast  <= inLast;
      end
    end
  end
endmodule // cfg_decompressor
`default_nettype wire

// file: src/cfg_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// AXI4-Lite slave front end
module cfg_axil_slave (
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic [cfg_startup_pkg::AW-1:0]     awaddr,
  input  wire logic                               awvalid,
  output var  logic                               awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output var  logic                               wready,
  output var  logic [1:0]                         bresp,
  output var  logic                               bvalid,
  input  wire logic                               bready,
  input  wire logic [cfg_startup_pkg::AW-1:0]     araddr,
  input  wire logic                               arvalid,
  output var  logic                               arready,
  output var  logic [31:0]                        rdata,
  output var  logic [1:0]                         rresp,
  output var  logic                               rvalid,
  input  wire logic                               rready,
  output var  logic                               wrEn,
  output var  logic [cfg_startup_pkg::AW-1:0]     wrAddr,
  output var  logic [31:0]                        wrData,
  output var  logic [3:0]                         wrStrb,
  input  wire logic                               wrHit,
  input  wire logic [31:0]                        rdData,
  input  wire logic                               rdHit
);
  import cfg_startup_pkg::*;
  logic awHeldFf;
  logic wHeldFf;
  logic nxt_awHeld;
  logic nxt_wHeld;
  logic nxt_bvalid;
  logic nxt_rvalid;

  assign wrEn = awHeldFf && wHeldFf && !bvalid;

  always_comb begin
    nxt_awHeld = (awHeldFf || (awvalid && awready)) && !wrEn;
    nxt_wHeld  = (wHeldFf || (wvalid && wready)) && !wrEn;
    nxt_bvalid = wrEn || (bvalid && !bready);
    nxt_rvalid = (arvalid && arready) || (rvalid && !rready);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeldFf <= 1'b0;
      wHeldFf  <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      wrAddr   <= '0;
      wrData   <= 32'h0;
      wrStrb   <= 4'h0;
    end else begin
      awHeldFf <= nxt_awHeld;
      wHeldFf  <= nxt_wHeld;
      awready  <= !nxt_awHeld && !nxt_bvalid;
      wready   <= !nxt_wHeld && !nxt_bvalid;
      bvalid   <= nxt_bvalid;
      if (awvalid && awready) begin
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrEn) begin
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      rvalid  <= nxt_rvalid;
      arready <= !nxt_rvalid;
      if (arvalid && arready) begin
        rdata <= rdHit ? rdData : 32'h0;
        rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule // cfg_axil_slave
`default_nettype wire

// file: src/cfg_startup_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RULE1: No auto restart: halt after error, wait
// RULE2: No auto restart: hold status line low
// RULE3: Restart request low then high reconfigures
// RULE4: Auto restart: pulse status low, then release
// RULE5: Auto restart: resume once status returns high
// RULE6: Config source resets on status pulse
// RULE7: All I/O tri-stated throughout configuration
// RULE8: Option off: tri-states released before clears
// RULE9: Option on: clears released before tri-states
// RULE10: Chip reset: clear pin low clears registers
// RULE11: Chip reset off: clear pin is user I/O
// RULE12: Chip OE: OE pin low tri-states user I/O
// RULE13: Chip OE off: OE pin is user I/O
// RULE14: Done output enabled: low during configuration
// RULE15: Done output released on entering user mode
// RULE16: Done output disabled: never driven
// RULE17: Compression on: expand the incoming stream
// RULE18: Compression off: pass data unchanged
// RULE19: Compression only in serial schemes
// RULE20: Status low in config/init is error; ignored later
// RULE21: Restart low anywhere: reset, tri-state, reconfigure
// RULE22: Options latched at configuration start only; the done output enable reads initDoneEn live from optionsFf
module cfg_startup_ctrl (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic [cfg_startup_pkg::AW-1:0]  awaddr,
  input  wire logic                            awvalid,
  output var  logic                            awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output var  logic                            wready,
  output var  logic [1:0]                      bresp,
  output var  logic                            bvalid,
  input  wire logic                            bready,
  input  wire logic [cfg_startup_pkg::AW-1:0]  araddr,
  input  wire logic                            arvalid,
  output var  logic                            arready,
  output var  logic [31:0]                     rdata,
  output var  logic [1:0]                      rresp,
  output var  logic                            rvalid,
  input  wire logic                            rready,
  input  wire logic                            configRestartRequestN,
  input  wire logic                            configStatusLineIn,
  output var  logic                            configStatusLineOut,
  output var  logic                            configStatusLineOe,
  input  wire cfg_startup_pkg::frame_t         frameIn,
  output var  logic                            frameReady,
  output var  logic                            cfgByteValid,
  output var  logic                            cfgByteLast,
  output var  logic [7:0]                      cfgByte,
  input  wire logic                            globalClearN,
  input  wire logic                            globalOutputEnable,
  output var  logic                            userClearPin,
  output var  logic                            userOePin,
  output var  logic                            regClear,
  output var  logic                            ioTristate,
  output var  logic                            initDoneOut,
  output var  logic                            initDoneOe,
  output var  logic                            userMode
);
  import cfg_startup_pkg::*;

  // ==========================================================
  // Register access
  function automatic logic regHit(input logic [AW-1:0] a);
    regHit = (a == OFS_OPTIONS) || (a == OFS_STATUS) ||
             (a == OFS_CONTROL) || (a == OFS_COUNT);
  endfunction

  state_t     stateFf;
  state_t     nxt_state;
  options_t   optionsFf;
  options_t   activeFf;
  logic [CNT_W-1:0] cntFf;
  logic       phaseFf;
  logic       errFlagFf;
  logic [15:0] countFf;
  logic       wrEn;
  logic [AW-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [31:0] rdData;
  logic       useCompress;
  logic       decLast;
  logic       errEvent;
  logic       clearErr;
  logic       nxt_phase;

  cfg_axil_slave u_axil (
    .clk     (clk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrEn    (wrEn),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .wrHit   (regHit(wrAddr)),
    .rdData  (rdData),
    .rdHit   (regHit(araddr))
  );

  always_comb begin
    case (araddr)
      OFS_OPTIONS: rdData = {25'h0, optionsFf};
      OFS_STATUS:  rdData = {26'h0, userMode, errFlagFf, 1'b0, stateFf};
      OFS_COUNT:   rdData = {16'h0, countFf};
      default:     rdData = 32'h0;
    endcase
  end

  assign clearErr = wrEn && wrAddr == OFS_CONTROL && wrStrb[0] && wrData[CTRL_CLRERR];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      optionsFf <= options_t'(OPTIONS_RST);
    end else if (wrEn && wrAddr == OFS_OPTIONS && wrStrb[0]) begin
      optionsFf <= options_t'(wrData[6:0]);
    end
  end

  // Snapshot so later software writes cannot disturb a running start-up, except initDoneEn, which the done output reads from optionsFf
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      activeFf <= options_t'(OPTIONS_RST);
    end else if (nxt_state == ST_CONFIG && stateFf != ST_CONFIG) begin
      activeFf <= optionsFf; // RULE22
    end
  end

  // ==========================================================
  // Configuration data path
  assign useCompress = activeFf.compress && activeFf.serialScheme; // RULE19
  assign errEvent    = stateFf == ST_CONFIG &&
                       frameIn.valid && frameReady && frameIn.error;

  cfg_decompressor u_decomp (
    .clk      (clk),
    .rst      (rst),
    .enable   (nxt_state == ST_CONFIG),
    .compress (useCompress),
    .inValid  (frameIn.valid),
    .inLast   (frameIn.last),
    .inData   (frameIn.data),
    .inReady  (frameReady),
    .outValid (cfgByteValid),
    .outLast  (cfgByteLast),
    .outData  (cfgByte)
  );

  assign decLast = cfgByteValid && cfgByteLast;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countFf <= 16'h0;
    end else if (stateFf != ST_CONFIG && nxt_state == ST_CONFIG) begin
      countFf <= 16'h0;
    end else if (cfgByteValid) begin
      countFf <= countFf + 16'h1;
    end
  end

  // Hardware set beats a same-cycle software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errFlagFf <= 1'b0;
    end else if (nxt_state == ST_ERRHOLD || nxt_state == ST_ERRPULSE) begin
      errFlagFf <= 1'b1;
    end else if (clearErr) begin
      errFlagFf <= 1'b0;
    end
  end

  // ==========================================================
  // Start-up sequencer
  always_comb begin
    nxt_state = stateFf;
    nxt_phase = phaseFf;
    if (!configRestartRequestN) begin
      nxt_state = ST_RESET; // RULE21 RULE3
      nxt_phase = 1'b0;
    end else begin
      case (stateFf)
        ST_POWERUP: begin
          if (cntFf == '0) nxt_state = ST_WAIT;
        end
        ST_RESET: begin
          nxt_state = ST_WAIT; // RULE3
        end
        ST_WAIT: begin
          if (configStatusLineIn) nxt_state = ST_CONFIG; // RULE5
        end
        ST_CONFIG: begin
          if (errEvent || !configStatusLineIn) begin // RULE20
            nxt_state = activeFf.autoRestart ? ST_ERRPULSE : ST_ERRHOLD;
          end else if (decLast) begin
            nxt_state = ST_INIT;
          end
        end
        ST_ERRHOLD: begin
          nxt_state = ST_ERRHOLD; // RULE1
        end
        ST_ERRPULSE: begin
          if (cntFf == '0) nxt_state = ST_WAIT; // RULE4
        end
        ST_INIT: begin
          if (!configStatusLineIn) begin // RULE20
            nxt_state = activeFf.autoRestart ? ST_ERRPULSE : ST_ERRHOLD;
            nxt_phase = 1'b0;
          end else if (cntFf == '0 && !phaseFf) begin
            nxt_phase = 1'b1;
          end else if (cntFf == '0) begin
            nxt_state = ST_USER;
            nxt_phase = 1'b0;
          end
        end
        ST_USER: begin
          nxt_state = ST_USER; // RULE20
        end
        default: begin
          nxt_state = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateFf <= ST_POWERUP;
      phaseFf <= 1'b0;
    end else begin
      stateFf <= nxt_state;
      phaseFf <= nxt_phase;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cntFf <= CNT_W'(POR_CYCLES - 1);
    end else if (nxt_state == ST_ERRPULSE && stateFf != ST_ERRPULSE) begin
      cntFf <= CNT_W'(PULSE_CYCLES - 1);
    end else if ((nxt_state == ST_INIT && stateFf != ST_INIT) || nxt_phase != phaseFf) begin
      cntFf <= CNT_W'(STEP_CYCLES - 1);
    end else if (cntFf != '0) begin
      cntFf <= cntFf - CNT_W'(1);
    end
  end

  // ==========================================================
  // Pin drivers, all registered; status, clear, tri-state and done pins from the next state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      configStatusLineOut <= 1'b0;
      configStatusLineOe  <= 1'b1;
    end else begin
      configStatusLineOut <= 1'b0;
      configStatusLineOe  <= nxt_state == ST_POWERUP || nxt_state == ST_RESET ||
                             nxt_state == ST_ERRHOLD || nxt_state == ST_ERRPULSE; // RULE2 RULE4
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regClear   <= 1'b1;
      ioTristate <= 1'b1;
    end else if (nxt_state == ST_USER) begin
      regClear   <= activeFf.chipReset && !globalClearN; // RULE10
      ioTristate <= activeFf.chipOe && !globalOutputEnable; // RULE12
    end else if (nxt_state == ST_INIT && nxt_phase) begin
      regClear   <= !activeFf.clearsFirst; // RULE9
      ioTristate <= activeFf.clearsFirst; // RULE8
    end else begin
      regClear   <= 1'b1;
      ioTristate <= 1'b1; // RULE7 RULE21
    end
  end

  // Pins whose option is off are handed through to user logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      userClearPin <= 1'b1;
      userOePin    <= 1'b1;
    end else begin
      userClearPin <= activeFf.chipReset ? 1'b1 : globalClearN; // RULE11
      userOePin    <= activeFf.chipOe ? 1'b1 : globalOutputEnable; // RULE13
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initDoneOut <= 1'b0;
      initDoneOe  <= 1'b0;
      userMode    <= 1'b0;
    end else begin
      initDoneOut <= 1'b0;
      initDoneOe  <= optionsFf.initDoneEn && nxt_state != ST_USER; // RULE14 RULE15 RULE16
      userMode    <= nxt_state == ST_USER;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqStatusPulse;
    configStatusLineOe [*4] ##1 !configStatusLineOe;
  endsequence

  sequence seqReleaseThenConfig;
    (stateFf == ST_WAIT) ##1 (stateFf == ST_CONFIG);
  endsequence

  AST_HOLD_AFTER_ERROR: assert property ( // RULE1
    (stateFf == ST_ERRHOLD && configRestartRequestN) |=> (stateFf == ST_ERRHOLD))
    else $error("error hold left without restart");

  AST_STATUS_LOW_HELD: assert property ( // RULE2
    (stateFf == ST_ERRHOLD) |-> configStatusLineOe)
    else $error("status line not driven low in error hold");

  AST_RESTART_RECONFIG: assert property ( // RULE3
    (stateFf == ST_RESET && configRestartRequestN) |=> (stateFf == ST_WAIT))
    else $error("restart release did not reconfigure");

  AST_AUTO_PULSE: assert property ( // RULE4
    (stateFf == ST_CONFIG && errEvent && activeFf.autoRestart && configRestartRequestN) |=> seqStatusPulse)
    else $error("automatic restart pulse wrong length");

  AST_RESUME_ON_HIGH: assert property ( // RULE5
    (stateFf == ST_WAIT && configStatusLineIn && configRestartRequestN) |-> seqReleaseThenConfig)
    else $error("did not resume when status high");

  AST_TRISTATE_CONFIG: assert property ( // RULE7
    (stateFf == ST_CONFIG) |-> (ioTristate && regClear))
    else $error("outputs enabled during configuration");

  AST_TRI_FIRST: assert property ( // RULE8
    ($fell(ioTristate) && stateFf == ST_INIT) |-> (regClear && !activeFf.clearsFirst))
    else $error("tri-states released in wrong order");

  AST_CLEAR_FIRST: assert property ( // RULE9
    ($fell(regClear) && stateFf == ST_INIT) |-> (ioTristate && activeFf.clearsFirst))
    else $error("clears released in wrong order");

  AST_CHIP_RESET: assert property ( // RULE10
    (stateFf == ST_USER && nxt_state == ST_USER && activeFf.chipReset && !globalClearN) |=> regClear)
    else $error("chip reset did not clear registers");

  AST_CHIP_OE: assert property ( // RULE12
    (stateFf == ST_USER && nxt_state == ST_USER && activeFf.chipOe && !globalOutputEnable) |=> ioTristate)
    else $error("chip output enable did not tri-state");

  AST_DONE_LOW: assert property ( // RULE14
    (stateFf == ST_CONFIG && $past(optionsFf.initDoneEn)) |-> initDoneOe)
    else $error("done output not low during configuration");

  AST_IGNORE_STATUS_USER: assert property ( // RULE20
    (stateFf == ST_USER && configRestartRequestN) |=> (stateFf == ST_USER && userMode))
    else $error("user mode left without restart");

  AST_RESTART_USER: assert property ( // RULE21
    (stateFf == ST_USER && !configRestartRequestN) |=> (stateFf == ST_RESET && ioTristate && !userMode))
    else $error("restart in user mode not honoured");
endmodule // cfg_startup_ctrl
`default_nettype wire

// file: tb/cfg_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Configuration source: replays a fixed stream, restarts on status low
module cfg_source_model (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    statusWire,
  input  wire logic                    frameReady,
  input  wire logic                    injectErr,
  output var  cfg_startup_pkg::frame_t frameIn
);
  import cfg_startup_pkg::*;
  // Marker 0x00 then count 2 gives three zeros when expanded
  localparam logic [7:0] STREAM [4] = '{8'h12, 8'h00, 8'h02, 8'h34};
  logic [2:0] idxFf;
  logic       pendFf;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idxFf   <= 3'h0;
      pendFf  <= 1'b0;
      frameIn <= '0;
    end else begin
      if (injectErr) pendFf <= 1'b1;
      if (!statusWire) begin
        idxFf         <= 3'h0;
        frameIn.valid <= 1'b0;
        frameIn.data  <= ~frameIn.data;
      end else if (!frameIn.valid || frameReady) begin
        if (idxFf < 3'h4) begin
          frameIn <= '{1'b1, idxFf == 3'h3, pendFf, STREAM[idxFf[1:0]]};
          idxFf   <= idxFf + 3'h1;
          if (pendFf) pendFf <= 1'b0;
        end else begin
          // Idle lines keep toggling so nothing stale is mistaken for data
          frameIn.valid <= 1'b0;
          frameIn.data  <= ~frameIn.data;
        end
      end
    end
  end
endmodule // cfg_source_model
`default_nettype wire

// file: tb/config_startup_option_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module config_startup_option_control_bench;
  import cfg_startup_pkg::*;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata, rdVal;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, rdResp;
  logic restartN, statOe, pullLow, injectErr, frameReady, clrN, oeIn, userClr, userOe, regClear, ioTri, doneOe, userMode;
  wire  statusWire = !(statOe || pullLow);
  frame_t frameIn;
  logic statOut, doneOut, byteV, byteL;
  logic [7:0] byteD;
  logic [15:0] byteSum;
  int failures, checks_done, k;
  cfg_startup_ctrl dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .configRestartRequestN(restartN),
    .configStatusLineIn(statusWire), .configStatusLineOut(statOut), .configStatusLineOe(statOe), .frameIn,
    .frameReady, .cfgByteValid(byteV), .cfgByteLast(byteL), .cfgByte(byteD), .globalClearN(clrN),
    .globalOutputEnable(oeIn), .userClearPin(userClr), .userOePin(userOe), .regClear, .ioTristate(ioTri),
    .initDoneOut(doneOut), .initDoneOe(doneOe), .userMode);
  cfg_source_model src (.clk, .rst, .statusWire, .frameReady, .injectErr, .frameIn);
  // Running sum of expanded bytes, last marker weighted in bit 8
  always_ff @(posedge clk or posedge rst) begin
    if (rst) byteSum <= 16'h0;
    else if (byteV) byteSum <= byteSum + {7'h0, byteL, byteD};
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Checking and ending
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    failures++;
    conclude();
  endtask
  // ==========================================================
  // Bus and wait helpers
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 100) hang();
    chk(bresp, RESP_OKAY);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    int i;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdVal = rdata; rdResp = rresp; rready <= 1'b0;
    if (i == 100) hang();
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return userMode;
      1: return regClear & ioTri;
      default: return statOe;
    endcase
  endfunction
  // Long bound covers the power-up release and a whole stream
  task automatic waitSig(input int s, input logic v);
    int i;
    for (i = 0; i < 2000 && pick(s) !== v; i++) @(posedge clk);
    if (i == 2000) hang();
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = '0;
    araddr = '0; wdata = '0; wstrb = '0; restartN = 1'b1; pullLow = 1'b0; injectErr = 1'b0; clrN = 1'b1; oeIn = 1'b1;
    failures = 0; checks_done = 0;
    cyc(20);
    rst <= 1'b0;
    rd(4'h2); chk(rdResp, RESP_SLVERR);
    wr(OFS_OPTIONS, 32'h7e);
    cyc(1);
    chk(ioTri, 1'b1);
    chk(doneOe, 1'b1);
    waitSig(1, 1'b0); chk({regClear, ioTri}, 2'b01);
    waitSig(0, 1'b1); chk(doneOe, 1'b0);
    rd(OFS_COUNT); chk(rdVal[15:0], 16'h5);
    chk(byteSum, 16'h146);
    oeIn <= 1'b0; cyc(2); chk(ioTri, 1'b1);
    oeIn <= 1'b1; clrN <= 1'b0; cyc(2); chk(regClear, 1'b1);
    clrN <= 1'b1; pullLow <= 1'b1; cyc(2); chk(userMode, 1'b1);
    pullLow <= 1'b0;
    wr(OFS_OPTIONS, 32'h00);
    restartN <= 1'b0; injectErr <= 1'b1; cyc(2); injectErr <= 1'b0;
    chk({userMode, ioTri, statOe, doneOe}, 4'b0110);
    restartN <= 1'b1; cyc(400);
    chk(statOe, 1'b1);
    chk({statOut, doneOut}, 2'b00);
    rd(OFS_STATUS); chk(rdVal[5:0], 6'h14);
    wr(OFS_OPTIONS, 32'h01);
    restartN <= 1'b0; injectErr <= 1'b1; cyc(2); injectErr <= 1'b0; restartN <= 1'b1;
    waitSig(2, 1'b0); waitSig(2, 1'b1);
    for (k = 0; k < 50 && statOe; k++) @(posedge clk);
    chk(k, PULSE_CYCLES);
    waitSig(1, 1'b0); chk({regClear, ioTri}, 2'b10);
    waitSig(0, 1'b1);
    clrN <= 1'b0; oeIn <= 1'b0; cyc(2); chk({userClr, userOe, regClear, ioTri}, 4'b0000);
    rd(OFS_COUNT); chk(rdVal[15:0], 16'h4);
    chk(byteSum, 16'h28e);
    wr(OFS_CONTROL, 32'h1);
    rd(OFS_STATUS); chk(rdVal[5:0], 6'h27);
    conclude();
  end
endmodule // config_startup_option_control_bench
`default_nettype wire
